// File: design/pbp_top.sv
// Parallel slave byte port with AXI4-Lite register access
`timescale 1ns/1ps
`include "pbp_params.svh"

// What this block does
// - Mode bit set turns the 8-bit data port into a parallel slave port.
// - External party reads and writes at any time, unrelated to the device clock.
// - External processor writes an 8-bit input latch and reads the 8-bit output latch on eight lines.
// - In slave mode the three control pins become read, write and select inputs.
// - Write happens when select and write strobe are first seen low; data captured then.
// - Read happens when select and read strobe are first seen low; latch driven.
// - Software write updates the output latch; software read returns pin levels in I/O mode, the captured byte in slave mode.
// - Read only while read strobe low and chip selected.
// - Select high: strobes ignored and data bus left undriven.
module pbp_top
(
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // AXI4-Lite write
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Pins: data bus and control pins (bit0 read, bit1 write, bit2 select)
   input  wire logic [7:0]    pd_in,
   input  wire logic [2:0]    pe_in,
   output pbp_pkg::pbp_pads_s pads,
   // Interrupts
   output logic               irq,
   output logic               irq_hi,
   output logic               irq_lo
);
   import pbp_pkg::*;

   function automatic logic pbp_mapped(input logic [7:0] a);
      case (a)
         `PBP_OFF_DPORT, `PBP_OFF_DLAT, `PBP_OFF_DDIR, `PBP_OFF_CPORT,
         `PBP_OFF_CLAT, `PBP_OFF_CSTAT, `PBP_OFF_PFLG, `PBP_OFF_PENA,
         `PBP_OFF_PPRI, `PBP_OFF_ACFG, `PBP_OFF_ISTAT, `PBP_OFF_ICLR,
         `PBP_OFF_IENA: return 1'b1;
         default:       return 1'b0;
      endcase
   endfunction

   pbp_pins_s  pin_s;
   logic [7:0] lat_d_r;
   logic [7:0] dir_d_r;
   logic [2:0] lat_c_r;
   logic [2:0] dir_c_r;
   logic       mode_r;
   logic       input_buffer_full_r;
   logic       output_buffer_full_r;
   logic       input_buffer_overflow_r;
   logic [7:0] in_byte_r;
   logic       spif_r;
   logic       spie_r;
   logic       spip_r;
   logic [7:0] acfg_r;
   logic [2:0] ist_r;
   logic [2:0] ien_r;
   logic       wr_act_r;
   logic       rd_act_r;
   logic       drive_r;
   logic       bvalid_r;
   logic [1:0] bresp_r;
   logic       rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] rd_mux;

   // ----------------------------------------------------------------------
   // Pin synchronisation and strobe detection
   // ----------------------------------------------------------------------
   // Strobes are asynchronous to mclk, so everything sees them two flops late
   pbp_sync #(.W(11), .RST_VAL(11'h7ff)) u_sync
   (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d_in  ({pe_in, pd_in}),
      .q_out (pin_s)
   );

   logic sel;
   logic wr_now;
   logic rd_now;
   logic wr_start;
   logic wr_end;
   logic rd_end;
   assign sel      = mode_r & ~pin_s.ctl[2];
   assign wr_now   = sel & ~pin_s.ctl[1];
   assign rd_now   = sel & ~pin_s.ctl[0];
   assign wr_start = wr_now & ~wr_act_r;
   assign wr_end   = ~wr_now & wr_act_r;
   assign rd_end   = ~rd_now & rd_act_r;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
         drive_r  <= 1'b0;
      end
      else
      begin
         wr_act_r <= wr_now;
         rd_act_r <= rd_now;
         drive_r  <= rd_now;
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite handshakes
   // ----------------------------------------------------------------------
   logic wr_go;
   logic rd_go;
   logic wr_hit;
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   assign wr_hit        = wr_go & s_axi_wstrb[0];
   assign rd_go         = s_axi_arvalid & ~rvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   logic w_dport;
   logic w_dlat;
   logic w_cstat;
   logic w_pflg;
   logic w_iclr;
   logic r_dport;
   assign w_dport = wr_hit && s_axi_awaddr == `PBP_OFF_DPORT;
   assign w_dlat  = wr_hit && s_axi_awaddr == `PBP_OFF_DLAT;
   assign w_cstat = wr_hit && s_axi_awaddr == `PBP_OFF_CSTAT;
   assign w_pflg  = wr_hit && s_axi_awaddr == `PBP_OFF_PFLG;
   assign w_iclr  = wr_hit && s_axi_awaddr == `PBP_OFF_ICLR;
   assign r_dport = rd_go && s_axi_araddr == `PBP_OFF_DPORT;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= `PBP_RESP_OK;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= pbp_mapped(s_axi_awaddr) ? `PBP_RESP_OK : `PBP_RESP_ERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // Software-written configuration
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         lat_d_r <= `PBP_RST_BYTE;
         dir_d_r <= `PBP_RST_DDIR;
         lat_c_r <= `PBP_RST_EV;
         dir_c_r <= `PBP_RST_CDIR;
         mode_r  <= 1'b0;
         spie_r  <= 1'b0;
         spip_r  <= 1'b0;
         acfg_r  <= `PBP_RST_BYTE;
         ien_r   <= `PBP_RST_EV;
      end
      else if (wr_hit)
      begin
         case (s_axi_awaddr)
            `PBP_OFF_DPORT, `PBP_OFF_DLAT: lat_d_r <= s_axi_wdata[7:0];
            `PBP_OFF_DDIR: dir_d_r <= s_axi_wdata[7:0];
            `PBP_OFF_CPORT, `PBP_OFF_CLAT: lat_c_r <= s_axi_wdata[2:0];
            `PBP_OFF_CSTAT:
            begin
               mode_r  <= s_axi_wdata[`PBP_B_MODE];
               dir_c_r <= s_axi_wdata[2:0];
            end
            `PBP_OFF_PENA: spie_r <= s_axi_wdata[`PBP_B_SPIRQ];
            `PBP_OFF_PPRI: spip_r <= s_axi_wdata[`PBP_B_SPIRQ];
            `PBP_OFF_ACFG: acfg_r <= s_axi_wdata[7:0];
            `PBP_OFF_IENA: ien_r  <= s_axi_wdata[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Buffer status; hardware set always beats software clear
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         input_buffer_full_r     <= 1'b0;
         output_buffer_full_r    <= 1'b0;
         input_buffer_overflow_r <= 1'b0;
         in_byte_r               <= `PBP_RST_BYTE;
      end
      else
      begin
         if (wr_start)
            in_byte_r <= pin_s.data;
         input_buffer_full_r     <= wr_start |
                                    (input_buffer_full_r & ~(r_dport & mode_r));
         input_buffer_overflow_r <= (wr_start & input_buffer_full_r) |
                                    (input_buffer_overflow_r &
                                     ~(w_cstat & ~s_axi_wdata[`PBP_B_IN_OVF]));
         output_buffer_full_r    <= (w_dport & mode_r) |
                                    (output_buffer_full_r & ~rd_end);
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt flags
   // ----------------------------------------------------------------------
   logic [2:0] ev;
   assign ev[`PBP_EV_WR] = wr_end;
   assign ev[`PBP_EV_RD] = rd_end;
   assign ev[`PBP_EV_OV] = wr_start & input_buffer_full_r;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         spif_r <= 1'b0;
         ist_r  <= `PBP_RST_EV;
      end
      else
      begin
         spif_r <= wr_end | rd_end |
                   (w_pflg ? s_axi_wdata[`PBP_B_SPIRQ] : spif_r);
         ist_r  <= ev | (ist_r & ~(w_iclr ? s_axi_wdata[2:0] : `PBP_RST_EV));
      end
   end

   assign irq    = |(ist_r & ien_r);
   assign irq_hi = spif_r & spie_r & spip_r;
   assign irq_lo = spif_r & spie_r & ~spip_r;

   // ----------------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------------
   always_comb
   begin
      rd_mux = `PBP_RST_BYTE;
      case (s_axi_araddr)
         // Slave mode returns the captured byte, otherwise pin levels
         `PBP_OFF_DPORT: rd_mux = mode_r ? in_byte_r : pin_s.data;
         `PBP_OFF_DLAT:  rd_mux = lat_d_r;
         `PBP_OFF_DDIR:  rd_mux = dir_d_r;
         `PBP_OFF_CPORT: rd_mux = {5'h00, pin_s.ctl};
         `PBP_OFF_CLAT:  rd_mux = {5'h00, lat_c_r};
         `PBP_OFF_CSTAT: rd_mux = {input_buffer_full_r, output_buffer_full_r,
                                   input_buffer_overflow_r, mode_r, 1'b0, dir_c_r};
         `PBP_OFF_PFLG:  rd_mux = {spif_r, 7'h00};
         `PBP_OFF_PENA:  rd_mux = {spie_r, 7'h00};
         `PBP_OFF_PPRI:  rd_mux = {spip_r, 7'h00};
         `PBP_OFF_ACFG:  rd_mux = acfg_r;
         `PBP_OFF_ISTAT: rd_mux = {5'h00, ist_r};
         `PBP_OFF_IENA:  rd_mux = {5'h00, ien_r};
         default:        rd_mux = `PBP_RST_BYTE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rvalid_r <= 1'b0;
         rresp_r  <= `PBP_RESP_OK;
         rdata_r  <= 32'h0000_0000;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= pbp_mapped(s_axi_araddr) ? `PBP_RESP_OK : `PBP_RESP_ERR;
         rdata_r  <= {24'h00_0000, rd_mux};
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------------
   // Control pins are never driven in slave mode, whatever their direction bits
   always_comb
   begin
      pads.data_o    = lat_d_r;
      pads.data_oe_n = mode_r ? {8{~drive_r}} : dir_d_r;
      pads.ctl_o     = lat_c_r;
      pads.ctl_oe_n  = mode_r ? `PBP_RST_CDIR : dir_c_r;
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_wr_first;
      mode_r && !pin_s.ctl[2] && !pin_s.ctl[1] && !wr_act_r;
   endsequence

   sequence s_rd_held;
      mode_r && !pin_s.ctl[2] && !pin_s.ctl[0];
   endsequence

   property p_wr_capture;
      s_wr_first |=> (in_byte_r == $past(pin_s.data)) && input_buffer_full_r;
   endproperty
   a_wr_capture: assert property (p_wr_capture)
      else $error("external write byte not captured");

   property p_rd_drive;
      s_rd_held ##1 mode_r |-> pads.data_oe_n == 8'h00;
   endproperty
   a_rd_drive: assert property (p_rd_drive)
      else $error("latch not driven during external read");

   property p_unsel_float;
      (mode_r && pin_s.ctl[2]) ##1 mode_r |-> pads.data_oe_n == 8'hff;
   endproperty
   a_unsel_float: assert property (p_unsel_float)
      else $error("data bus driven while not selected");

   property p_rd_high;
      (mode_r && pin_s.ctl[0]) |=> !drive_r;
   endproperty
   a_rd_high: assert property (p_rd_high)
      else $error("drive without read strobe");

   property p_overflow;
      (wr_start && input_buffer_full_r) |=> input_buffer_overflow_r && ist_r[`PBP_EV_OV];
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow not flagged");

   property p_out_full_set;
      (w_dport && mode_r) |=> output_buffer_full_r;
   endproperty
   a_out_full_set: assert property (p_out_full_set)
      else $error("output full not set by software write");

   property p_flag_end;
      (wr_end || rd_end) |=> spif_r && (!spie_r || (irq_hi ^ irq_lo));
   endproperty
   a_flag_end: assert property (p_flag_end)
      else $error("port flag or level wrong after access");

   property p_sw_latch;
      (w_dport || w_dlat) |=> pads.data_o == $past(s_axi_wdata[7:0]);
   endproperty
   a_sw_latch: assert property (p_sw_latch)
      else $error("software write did not reach latch");

   property p_gpio_dir;
      !mode_r |-> pads.data_oe_n == dir_d_r && pads.ctl_oe_n == dir_c_r;
   endproperty
   a_gpio_dir: assert property (p_gpio_dir)
      else $error("pins not under direction bits in I/O mode");

   property p_ctl_input;
      mode_r |-> pads.ctl_oe_n == 3'h7;
   endproperty
   a_ctl_input: assert property (p_ctl_input)
      else $error("control pin driven in slave mode");

   property p_bresp;
      wr_go |=> bvalid_r ##1 (s_axi_bvalid || $past(s_axi_bready));
   endproperty
   a_bresp: assert property (p_bresp)
      else $error("write response missing");

endmodule

// File: design/pbp_params.svh
// Offsets, field positions, reset values and answer codes of the slave byte port
`ifndef PBP_PARAMS_SVH
`define PBP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PBP_OFF_DPORT  8'h00
`define PBP_OFF_DLAT   8'h04
`define PBP_OFF_DDIR   8'h08
`define PBP_OFF_CPORT  8'h0c
`define PBP_OFF_CLAT   8'h10
`define PBP_OFF_CSTAT  8'h14
`define PBP_OFF_PFLG   8'h18
`define PBP_OFF_PENA   8'h1c
`define PBP_OFF_PPRI   8'h20
`define PBP_OFF_ACFG   8'h24
`define PBP_OFF_ISTAT  8'h28
`define PBP_OFF_ICLR   8'h2c
`define PBP_OFF_IENA   8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PBP_B_IN_FULL  7
`define PBP_B_OUT_FULL 6
`define PBP_B_IN_OVF   5
`define PBP_B_MODE  4
`define PBP_B_SPIRQ 7
`define PBP_EV_WR   0
`define PBP_EV_RD   1
`define PBP_EV_OV   2

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define PBP_RST_DDIR 8'hff
`define PBP_RST_CDIR 3'h7
`define PBP_RST_BYTE 8'h00
`define PBP_RST_EV   3'h0
`define PBP_RESP_OK  2'h0
`define PBP_RESP_ERR 2'h2

`endif

// File: design/pbp_pkg.sv
// Types shared by the slave byte port design
package pbp_pkg;

   // Pad drive toward the data and control pins; oe_n low while driving
   typedef struct packed
   {
      logic [7:0] data_o;
      logic [7:0] data_oe_n;
      logic [2:0] ctl_o;
      logic [2:0] ctl_oe_n;
   } pbp_pads_s;

   // Synchronised pin levels
   typedef struct packed
   {
      logic [2:0] ctl;
      logic [7:0] data;
   } pbp_pins_s;

endpackage

// File: design/pbp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pbp_sync
#(
   parameter int             W       = 11,
   parameter logic [W-1:0]   RST_VAL = '1
)
(
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // Levels
   input  wire logic [W-1:0]  d_in,
   output logic [W-1:0]       q_out
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         meta_r <= RST_VAL;
         q_out  <= RST_VAL;
      end
      else
      begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule

// File: verification/pbp_cpu_model.sv
// External byte-wide processor that strobes the slave port pins
`timescale 1ns/1ps
module pbp_cpu_model
(
   // Clock
   input  wire logic        mclk,
   // Pins seen from the processor
   input  wire logic [7:0]  bus_in,
   output logic [2:0]       ctl_n,
   output logic [7:0]       bus_out
);
   initial
   begin
      ctl_n   = 3'h7;
      bus_out = 8'h00;
   end

   // ----------------------------------------------------------------
   // One strobe, c = {cs_n, wr_n, rd_n}
   // ----------------------------------------------------------------
   // Phases of 5 and 4 cycles; data held past the capture edge
   task automatic access(input logic [2:0] c, input logic [7:0] b,
                         output logic [7:0] r);
      @(posedge mclk);
      bus_out <= c[1] ? ~bus_out : b;
      ctl_n   <= c;
      repeat (5) @(posedge mclk);
      r = bus_in;
      ctl_n   <= 3'h7;
      repeat (4) @(posedge mclk);
      // Released bus shows a changed level, never the old byte
      bus_out <= ~bus_out;
   endtask
endmodule

// File: verification/parallel_slave_byte_port_tb.sv
// Self-checking bench for the slave byte port
`timescale 1ns/1ps
`include "pbp_params.svh"
module parallel_slave_byte_port_tb;
   logic               mclk, rst_n, drv_seen;
   logic [7:0]         s_axi_awaddr, s_axi_araddr, pd_in, bus_out, rb;
   logic [31:0]        s_axi_wdata, s_axi_rdata;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic               s_axi_rready, irq, irq_hi, irq_lo;
   logic [2:0]         pe_in, ctl_n;
   pbp_pkg::pbp_pads_s pads;
   int                 err_total, n_checks, cyc;

   pbp_top dut (.*);

   pbp_cpu_model m
   (
      .mclk    (mclk),
      .bus_in  (pd_in),
      .ctl_n   (ctl_n),
      .bus_out (bus_out)
   );

   // Wire levels: whoever has its enable low wins the pin
   assign pd_in = (pads.data_oe_n & bus_out) | (~pads.data_oe_n & pads.data_o);
   assign pe_in = (pads.ctl_oe_n & ctl_n) | (~pads.ctl_oe_n & pads.ctl_o);

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      if (pads.data_oe_n !== 8'hff)
         drv_seen <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do @(posedge mclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      rs = s_axi_bresp;
      s_axi_bready  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge mclk);
      d  = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready  <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      rd(a, d);
      chk({rs, d}, {`PBP_RESP_OK, 24'h0, e});
   endtask

   task automatic clr;
      wr(`PBP_OFF_ICLR, 8'h07);
      wr(`PBP_OFF_PFLG, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      rc(`PBP_OFF_DDIR, `PBP_RST_DDIR);
      rc(`PBP_OFF_CSTAT, 8'h07);
      rc(`PBP_OFF_PFLG, 8'h00);
      rc(`PBP_OFF_PENA, 8'h00);
      rc(`PBP_OFF_PPRI, 8'h00);
      rc(`PBP_OFF_ACFG, 8'h00);
      rc(`PBP_OFF_ISTAT, 8'h00);
      chk(34'({irq, irq_hi, irq_lo}), 34'h0);
      rd(8'h3c, d);
      chk({rs, d}, {`PBP_RESP_ERR, 32'h0});
      wr(8'h40, 8'h11);
      chk(34'(rs), 34'(`PBP_RESP_ERR));
      chk(34'(pads.data_oe_n), 34'hff);
      $display("test reset done");
   endtask

   task automatic t_gpio;
      wr(`PBP_OFF_DPORT, 8'hc3);
      wr(`PBP_OFF_DDIR, 8'h00);
      rc(`PBP_OFF_DLAT, 8'hc3);
      // Byte lane 0 off: answered but nothing stored
      s_axi_wstrb <= 4'h0;
      wr(`PBP_OFF_DLAT, 8'h00);
      s_axi_wstrb <= 4'hf;
      chk(34'(rs), 34'(`PBP_RESP_OK));
      rc(`PBP_OFF_DLAT, 8'hc3);
      rc(`PBP_OFF_DPORT, 8'hc3);
      chk(34'(pads.data_oe_n), 34'h00);
      // Control pins 1:0 as outputs in I/O mode
      wr(`PBP_OFF_CLAT, 8'h05);
      wr(`PBP_OFF_CSTAT, 8'h04);
      chk(34'({pads.ctl_oe_n, pads.ctl_o}), 34'h25);
      rc(`PBP_OFF_CPORT, 8'h05);
      wr(`PBP_OFF_CSTAT, 8'h07);
      wr(`PBP_OFF_DDIR, 8'hff);
      // Mode off: strobes are plain pin levels
      m.access(3'h1, 8'h77, rb);
      rc(`PBP_OFF_ISTAT, 8'h00);
      $display("test gpio done");
   endtask

   task automatic t_setup;
      wr(`PBP_OFF_CSTAT, 8'h17);
      wr(`PBP_OFF_ACFG, 8'h07);
      wr(`PBP_OFF_IENA, 8'h07);
      wr(`PBP_OFF_PENA, 8'h80);
      wr(`PBP_OFF_PPRI, 8'h80);
      rc(`PBP_OFF_CSTAT, 8'h17);
      rc(`PBP_OFF_ACFG, 8'h07);
      $display("test setup done");
   endtask

   task automatic t_wr;
      m.access(3'h1, 8'ha5, rb);
      rc(`PBP_OFF_CSTAT, 8'h97);
      rc(`PBP_OFF_ISTAT, 8'h01);
      rc(`PBP_OFF_PFLG, 8'h80);
      chk(34'({irq, irq_hi, irq_lo}), 34'h6);
      rc(`PBP_OFF_DPORT, 8'ha5);
      rc(`PBP_OFF_CSTAT, 8'h17);
      clr();
      chk(34'({irq, irq_hi, irq_lo}), 34'h0);
      $display("test ext write done");
   endtask

   task automatic t_ovf;
      m.access(3'h1, 8'h5a, rb);
      m.access(3'h1, 8'h3e, rb);
      rc(`PBP_OFF_CSTAT, 8'hb7);
      rc(`PBP_OFF_ISTAT, 8'h05);
      wr(`PBP_OFF_CSTAT, 8'h17);
      rc(`PBP_OFF_CSTAT, 8'h97);
      rc(`PBP_OFF_DPORT, 8'h3e);
      clr();
      $display("test overflow done");
   endtask

   task automatic t_rd;
      wr(`PBP_OFF_DPORT, 8'h3c);
      rc(`PBP_OFF_CSTAT, 8'h57);
      m.access(3'h2, 8'h00, rb);
      chk(34'(rb), 34'h3c);
      rc(`PBP_OFF_CSTAT, 8'h17);
      rc(`PBP_OFF_ISTAT, 8'h02);
      clr();
      $display("test ext read done");
   endtask

   task automatic t_nosel;
      drv_seen <= 1'b0;
      m.access(3'h4, 8'h81, rb);
      m.access(3'h3, 8'h00, rb);
      rc(`PBP_OFF_ISTAT, 8'h00);
      rc(`PBP_OFF_CSTAT, 8'h17);
      chk(34'(drv_seen), 34'h0);
      $display("test deselect done");
   endtask

   task automatic t_irq;
      m.access(3'h1, 8'h12, rb);
      chk(34'({irq, irq_hi, irq_lo}), 34'h6);
      wr(`PBP_OFF_PPRI, 8'h00);
      chk(34'({irq, irq_hi, irq_lo}), 34'h5);
      wr(`PBP_OFF_PENA, 8'h00);
      wr(`PBP_OFF_IENA, 8'h00);
      chk(34'({irq, irq_hi, irq_lo}), 34'h0);
      rc(`PBP_OFF_PFLG, 8'h80);
      rc(`PBP_OFF_DPORT, 8'h12);
      clr();
      $display("test interrupt done");
   endtask

   task automatic end_of_test;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, drv_seen} = 3'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata  = 32'h0;
      s_axi_wstrb  = 4'hf;
      err_total    = 0;
      n_checks     = 0;
      cyc          = 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_gpio();
      t_setup();
      t_wr();
      t_ovf();
      t_rd();
      t_nosel();
      t_irq();
      end_of_test();
   end
endmodule
